//--- dv/afmc_ctrl_tb.sv
// Self-checking bench of the FIFO pin controller against a queue model
`timescale 1ns/1ps
`include "afmc_defs.svh"
module afmc_ctrl_tb;
    localparam int DEPTH = 8;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic        awready, wready, bvalid, arready, rvalid, irq, wr_n, rd_n, init_all_n;
    logic [1:0]  bresp, rresp, r;
    logic [0:0]  lead_n, ef_n, ff_n;
    logic [8:0]  to_dev, from_dev, w, ext_d = 9'h0;
    logic        ext_wr_n = 1'b1, ext_rd_n = 1'b1, ext_sel = 1'b0, hf_n, casc = 1'b0;
    logic [8:0]  ref_q[$], hist[$];
    int          miscompares = 0, n_tests = 0, seed = 32'hef65, cycles = 0;
    ////////////////////////////////////////////////////////////////////////
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    afmc_ctrl #(.W(9), .NDEV(1), .ADDR_W(8)) i_afmc_ctrl (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
        .wr_n(wr_n), .rd_n(rd_n), .init_all_n(init_all_n), .lead_or_replay_n(lead_n),
        .data_to_dev(to_dev), .data_from_dev(from_dev), .empty_flag_n(ef_n),
        .full_flag_n(ff_n), .over_half_flag_n(hf_n));
    // Bench strobes join the controller's as a second writer and reader
    afmc_dev_model #(.W(9), .DEPTH(DEPTH)) i_afmc_dev_model (
        .wr_n(wr_n & ext_wr_n), .rd_n(rd_n & ext_rd_n), .init_all_n(init_all_n),
        .replay_n(lead_n[0]), .chained(casc), .d(ext_sel ? ext_d : to_dev), .q(from_dev),
        .empty_flag_n(ef_n[0]), .full_flag_n(ff_n[0]), .over_half_flag_n(hf_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic idle();
        do axi_rd(`AFMC_OFS_STAT); while (v[`AFMC_ST_BUSY] !== 1'b0);
    endtask
    task automatic order(input logic [7:0] a, input logic [31:0] d);
        axi_wr(a, d);
        idle();
    endtask
    task automatic chk_stat();
        axi_rd(`AFMC_OFS_STAT);
        chk("status", v[3:1], {ref_q.size() > DEPTH / 2, ref_q.size() == DEPTH,
            ref_q.size() == 0});
    endtask
    task automatic push(input logic [8:0] x);
        order(`AFMC_OFS_WDATA, {23'h0, x});
        if (ref_q.size() < DEPTH) begin
            ref_q.push_back(x);
            hist.push_back(x);
        end
        chk_stat();
    endtask
    task automatic pop();
        order(`AFMC_OFS_CMD, 32'h4);
        if (ref_q.size() > 0) begin
            axi_rd(`AFMC_OFS_RDATA);
            chk("rdata", v, {23'h0, ref_q.pop_front()});
        end
        chk_stat();
    endtask
    task automatic clear();
        order(`AFMC_OFS_CMD, 32'h1);
        ref_q.delete();
        hist.delete();
        axi_rd(`AFMC_OFS_IRQ);
    endtask
    task automatic refused();
        axi_rd(`AFMC_OFS_IRQ);
        chk("refused event", v[`AFMC_EV_REFUSED], 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`AFMC_OFS_MODE);
        chk("mode reset", v, 32'h0);
        axi_rd(`AFMC_OFS_MASK);
        chk("mask reset", v, 32'h0);
        axi_rd(8'h40);
        chk("unmapped read", r, 2'h2);
        axi_wr(8'h40, 32'h0);
        chk("unmapped write", r, 2'h2);
        chk("standalone lead", lead_n, 1'b1);
        clear();
        chk_stat();
        axi_wr(`AFMC_OFS_MASK, 32'h9);
        push(9'($random(seed)));
        chk("irq raised", irq, 1'b1);
        axi_rd(`AFMC_OFS_IRQ);
        chk("done event", v[`AFMC_EV_DONE], 1'b1);
        repeat (2) @(posedge aclk);
        chk("irq cleared", irq, 1'b0);
        repeat (DEPTH) push(9'($random(seed)));
        refused();
        repeat (DEPTH + 1) pop();
        refused();
        repeat (6) begin
            push(9'($random(seed)));
            push(9'($random(seed)));
            pop();
            pop();
        end
        clear();
        repeat (3) push(9'($random(seed)));
        repeat (2) pop();
        order(`AFMC_OFS_CMD, 32'h2);
        ref_q = hist;
        repeat (3) pop();
        axi_wr(`AFMC_OFS_MODE, 32'h2);
        axi_wr(`AFMC_OFS_CMD, 32'h4);
        repeat (10) @(posedge aclk);
        chk("read held", rd_n, 1'b0);
        w = 9'($random(seed));
        @(posedge aclk);
        ext_sel <= 1'b1;
        ext_d <= w;
        @(posedge aclk);
        ext_wr_n <= 1'b0;
        @(posedge aclk);
        ext_wr_n <= 1'b1;
        @(posedge aclk);
        ext_sel <= 1'b0;
        idle();
        axi_rd(`AFMC_OFS_RDATA);
        chk("flow read", v, {23'h0, w});
        chk_stat();
        repeat (DEPTH) push(9'($random(seed)));
        w = 9'($random(seed));
        axi_wr(`AFMC_OFS_WDATA, {23'h0, w});
        repeat (10) @(posedge aclk);
        chk("write held", wr_n, 1'b1);
        ext_rd_n <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("outside read", from_dev, ref_q.pop_front());
        ext_rd_n <= 1'b1;
        idle();
        ref_q.push_back(w);
        repeat (DEPTH) pop();
        casc <= 1'b1;
        axi_wr(`AFMC_OFS_MODE, 32'h1);
        repeat (2) @(posedge aclk);
        chk("lead held", lead_n, 1'b0);
        order(`AFMC_OFS_CMD, 32'h2);
        refused();
        push(9'($random(seed)));
        pop();
        report_and_stop();
    end
endmodule

//--- dv/afmc_dev_model.sv
// Behavioural FIFO device driven through its strobe, clear and replay pins
`timescale 1ns/1ps
module afmc_dev_model #(
    parameter int W     = 9,
    parameter int DEPTH = 8
) (
    // Strobes
    input  wire logic         wr_n,
    input  wire logic         rd_n,
    input  wire logic         init_all_n,
    input  wire logic         replay_n,
    input  wire logic         chained,
    // Data and flags
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q,
    output logic              empty_flag_n,
    output logic              full_flag_n,
    output logic              over_half_flag_n
);
    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] last = '0;
    logic         last_rd = 1'b0;
    // Cascaded: the lead pin marks the first-load device, whose pointers are enabled
    wire          active = !chained || !replay_n;
    int           wp   = 0;
    int           rp   = 0;
    ////////////////////////////////////////////////////////////////////////
    always @(negedge init_all_n) begin
        wp = 0;
        rp = 0;
        last_rd = 1'b0;
    end
    always @(negedge replay_n) if (init_all_n && !chained) rp = 0;
    always @(posedge wr_n) if (init_all_n && active && wp - rp < DEPTH) begin
        mem[wp % DEPTH] = d;
        wp++;
    end
    // Falling read on the last word raises empty at once, not at the rising edge
    always @(negedge rd_n) last_rd = active && (wp - rp == 1);
    always @(posedge rd_n) last_rd = 1'b0;
    always @(posedge rd_n) if (init_all_n && active && wp != rp) begin
        last = mem[rp % DEPTH];
        rp++;
    end
    ////////////////////////////////////////////////////////////////////////
    // Released bus shows the inverse of the last word, so stale data never matches
    assign q                = (!rd_n && wp != rp) ? mem[rp % DEPTH] : ~last;
    assign empty_flag_n     = (wp != rp) && !last_rd;
    assign full_flag_n      = (wp - rp != DEPTH);
    assign over_half_flag_n = !(wp - rp > DEPTH / 2);
endmodule

//--- verilog/afmc_ctrl.sv
// Top of the FIFO pin controller: AXI4-Lite registers, interrupt and the pin sequencer
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "afmc_defs.svh"
// How it works
// - In cascade, the first device's lead pin is held low, all others high.
// - Composite empty and full are the NOR of active-low per-device flags.
// - After that word is taken, the read strobe is raised to advance the pointer.
// - A waiting write goes out once full clears; one strobe pulse per word.
module afmc_ctrl #(
    parameter int W      = 9,
    parameter int NDEV   = 4,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write channels
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Interrupt
    output logic                   irq,
    // FIFO device pins
    output logic                   wr_n,
    output logic                   rd_n,
    output logic                   init_all_n,
    output logic [NDEV-1:0]        lead_or_replay_n,
    output logic [W-1:0]           data_to_dev,
    input  wire logic [W-1:0]      data_from_dev,
    input  wire logic [NDEV-1:0]   empty_flag_n,
    input  wire logic [NDEV-1:0]   full_flag_n,
    input  wire logic              over_half_flag_n
);
    import afmc_pkg::*;

    if (W < 1 || W > 32 || ADDR_W < 8 || NDEV < 1)
        $error("afmc_ctrl: width, address width or device count out of range");

    // Address decode shared by both bus directions
    function automatic logic mapped(input logic [7:0] a);
        return a == `AFMC_OFS_CMD || a == `AFMC_OFS_WDATA || a == `AFMC_OFS_RDATA
            || a == `AFMC_OFS_STAT || a == `AFMC_OFS_IRQ || a == `AFMC_OFS_MASK
            || a == `AFMC_OFS_MODE;
    endfunction

    afmc_seq_if #(.W(W)) sq_if ();

    logic [1:0]   mode_ff;
    logic [3:0]   mask_ff;
    logic [3:0]   stat_ff, nxt_stat;
    logic         busy_ff;
    logic         go_ff;
    afmc_op_t     op_ff;
    logic [W-1:0] wdat_ff;
    logic         empty_d_ff;
    logic         full_d_ff;
    logic [31:0]  rd_word;
    afmc_op_t     cmd_op;

    ////////////////////////////////////////////////////////////////////////////////
    // Write path: address and data are taken together, one response each
    wire [7:0] wa      = s_axi_awaddr[7:0];
    wire [7:0] ra      = s_axi_araddr[7:0];
    wire       wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    wire       wr_lane = wr_fire && s_axi_wstrb[0];
    wire       wr_cmd  = wr_lane && wa == `AFMC_OFS_CMD && |s_axi_wdata[2:0];
    wire       wr_wdat = wr_lane && wa == `AFMC_OFS_WDATA;
    wire       wr_mask = wr_lane && wa == `AFMC_OFS_MASK;
    wire       wr_mode = wr_lane && wa == `AFMC_OFS_MODE;
    wire       order   = wr_cmd || wr_wdat;
    wire       start   = order && !busy_ff;
    wire       rd_fire = s_axi_arready && s_axi_arvalid;
    wire       irq_clr = rd_fire && ra == `AFMC_OFS_IRQ;

    assign cmd_op = wr_wdat ? AFMC_OP_WR
                  : s_axi_wdata[`AFMC_CMD_CLR] ? AFMC_OP_CLR
                  : s_axi_wdata[`AFMC_CMD_RT] ? AFMC_OP_RT
                  : AFMC_OP_RD;

    // Events: done, empty rising, full rising, refused (device or busy)
    wire [3:0] events = {sq_if.refused || (order && busy_ff),
                         sq_if.full && !full_d_ff,
                         sq_if.empty && !empty_d_ff,
                         sq_if.done};
    // A new event wins over the clear done by the read
    assign nxt_stat = (stat_ff & ~{4{irq_clr}}) | events;

    wire [3:0] live = {sq_if.half, sq_if.full, sq_if.empty, busy_ff};

    assign rd_word = ra == `AFMC_OFS_RDATA ? 32'(sq_if.rdata)
                   : ra == `AFMC_OFS_STAT  ? {28'h0, live}
                   : ra == `AFMC_OFS_IRQ   ? {28'h0, stat_ff}
                   : ra == `AFMC_OFS_MASK  ? {28'h0, mask_ff}
                   : ra == `AFMC_OFS_MODE  ? {30'h0, mode_ff}
                   : 32'h0;

    assign sq_if.go      = go_ff;
    assign sq_if.op      = op_ff;
    assign sq_if.wdata   = wdat_ff;
    assign sq_if.cascade = mode_ff[`AFMC_MODE_CASC];
    assign sq_if.wait_en = mode_ff[`AFMC_MODE_WAIT];

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AFMC_RESP_OK;
        end else begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(wa) ? `AFMC_RESP_OK : `AFMC_RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `AFMC_RESP_OK;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= mapped(ra) ? `AFMC_RESP_OK : `AFMC_RESP_ERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Control registers and the order handed to the sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ff    <= `AFMC_MODE_RST;
            mask_ff    <= `AFMC_MASK_RST;
            stat_ff    <= 4'h0;
            irq        <= 1'b0;
            busy_ff    <= 1'b0;
            go_ff      <= 1'b0;
            op_ff      <= AFMC_OP_WR;
            wdat_ff    <= '0;
            empty_d_ff <= 1'b1;
            full_d_ff  <= 1'b0;
        end else begin
            stat_ff    <= nxt_stat;
            irq        <= |(nxt_stat & mask_ff);
            go_ff      <= start;
            busy_ff    <= start || (busy_ff && !sq_if.done);
            empty_d_ff <= sq_if.empty;
            full_d_ff  <= sq_if.full;
            if (wr_mask) begin
                mask_ff <= s_axi_wdata[3:0];
            end
            if (wr_mode && !busy_ff) begin
                mode_ff <= s_axi_wdata[1:0];
            end
            if (start) begin
                op_ff   <= cmd_op;
                wdat_ff <= s_axi_wdata[W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    afmc_seq #(
        .W    (W),
        .NDEV (NDEV)
    ) u_seq (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .sq               (sq_if.seq),
        .wr_n             (wr_n),
        .rd_n             (rd_n),
        .init_all_n       (init_all_n),
        .lead_or_replay_n (lead_or_replay_n),
        .data_to_dev      (data_to_dev),
        .data_from_dev    (data_from_dev),
        .empty_flag_n     (empty_flag_n),
        .full_flag_n      (full_flag_n),
        .over_half_flag_n (over_half_flag_n)
    );
endmodule

//--- verilog/afmc_defs.svh
// Register map, field positions, reset values and pin timing counts of the FIFO pin controller
`ifndef AFMC_DEFS_SVH
`define AFMC_DEFS_SVH
`define AFMC_CLK_NS     10
`define AFMC_T_PW_NS    10
`define AFMC_T_REC_NS   5
`define AFMC_T_ACC_NS   10
`define AFMC_T_FLAG_NS  10
`define AFMC_CEIL(t)    (((t) + `AFMC_CLK_NS - 1) / `AFMC_CLK_NS)
`define AFMC_PW_CYC     `AFMC_CEIL(`AFMC_T_PW_NS)
`define AFMC_ACC_CYC    (`AFMC_CEIL(`AFMC_T_ACC_NS) + 1)
`define AFMC_REC_CYC    (`AFMC_CEIL(`AFMC_T_REC_NS) + `AFMC_CEIL(`AFMC_T_FLAG_NS))
`define AFMC_OFS_CMD    8'h00
`define AFMC_OFS_WDATA  8'h04
`define AFMC_OFS_RDATA  8'h08
`define AFMC_OFS_STAT   8'h0c
`define AFMC_OFS_IRQ    8'h10
`define AFMC_OFS_MASK   8'h14
`define AFMC_OFS_MODE   8'h18
`define AFMC_CMD_CLR    0
`define AFMC_CMD_RT     1
`define AFMC_CMD_RD     2
`define AFMC_MODE_CASC  0
`define AFMC_MODE_WAIT  1
`define AFMC_ST_BUSY    0
`define AFMC_ST_EMPTY   1
`define AFMC_ST_FULL    2
`define AFMC_ST_HALF    3
`define AFMC_EV_DONE    0
`define AFMC_EV_EMPTY   1
`define AFMC_EV_FULL    2
`define AFMC_EV_REFUSED 3
`define AFMC_MODE_RST   2'h0
`define AFMC_MASK_RST   4'h0
`define AFMC_RESP_OK    2'h0
`define AFMC_RESP_ERR   2'h2
`endif

//--- verilog/afmc_pkg.sv
// Types shared by the FIFO pin controller modules
package afmc_pkg;
    typedef enum logic [1:0] {
        AFMC_OP_WR  = 2'b00,
        AFMC_OP_RD  = 2'b01,
        AFMC_OP_CLR = 2'b10,
        AFMC_OP_RT  = 2'b11
    } afmc_op_t;
    typedef enum logic [1:0] {
        AFMC_S_IDLE = 2'b00,
        AFMC_S_HOLD = 2'b01,
        AFMC_S_LOW  = 2'b10,
        AFMC_S_REC  = 2'b11
    } afmc_state_t;
endpackage

//--- verilog/afmc_seq.sv
// Pin sequencer: shapes strobe, clear and replay pulses toward the FIFO devices
`timescale 1ns/1ps
`include "afmc_defs.svh"
module afmc_seq #(
    parameter int W    = 9,
    parameter int NDEV = 4
) (
    // Clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // Orders
    afmc_seq_if.seq              sq,
    // Device pins
    output logic                 wr_n,
    output logic                 rd_n,
    output logic                 init_all_n,
    output logic [NDEV-1:0]      lead_or_replay_n,
    output logic [W-1:0]         data_to_dev,
    input  wire logic [W-1:0]    data_from_dev,
    input  wire logic [NDEV-1:0] empty_flag_n,
    input  wire logic [NDEV-1:0] full_flag_n,
    input  wire logic            over_half_flag_n
);
    import afmc_pkg::*;

    localparam logic [3:0] PW_CYC  = 4'(`AFMC_PW_CYC);
    localparam logic [3:0] ACC_CYC = 4'(`AFMC_ACC_CYC);
    localparam logic [3:0] REC_CYC = 4'(`AFMC_REC_CYC);

    if (`AFMC_PW_CYC > 15 || `AFMC_ACC_CYC > 15 || `AFMC_REC_CYC > 15 || NDEV < 1)
        $error("afmc_seq: timing counts or device count out of range");

    // Composite flag of active-low per-device flags: asserted only when all are asserted
    function automatic logic all_flagged(input logic [NDEV-1:0] f_n);
        return ~(|f_n);
    endfunction

    afmc_state_t         state_ff, nxt_state;
    afmc_op_t            op_ff, nxt_op;
    logic [3:0]          cnt_ff, nxt_cnt;
    logic                seen_ff, done_ff, refused_ff;
    logic [W-1:0]        rdata_ff;
    logic [NDEV-1:0]     nxt_lead;

    ////////////////////////////////////////////////////////////////////////////////
    wire comp_empty = all_flagged(empty_flag_n);
    wire comp_full  = all_flagged(full_flag_n);
    wire is_rd      = (op_ff == AFMC_OP_RD);
    wire last_cnt   = (cnt_ff == (is_rd ? ACC_CYC : PW_CYC) - 4'h1);
    wire rec_last   = (cnt_ff == REC_CYC - 4'h1);
    // Read held low on an empty buffer waits for a write to flow through
    wire rd_hold    = is_rd && comp_empty && !seen_ff;
    wire go_wr_blk  = (sq.op == AFMC_OP_WR) && comp_full;
    wire go_rd_blk  = (sq.op == AFMC_OP_RD) && comp_empty;
    wire go_refuse  = ((go_wr_blk || go_rd_blk) && !sq.wait_en)
                    || ((sq.op == AFMC_OP_RT) && sq.cascade);
    wire idle_go    = (state_ff == AFMC_S_IDLE) && sq.go;
    wire nxt_low    = (nxt_state == AFMC_S_LOW);

    assign nxt_op     = idle_go ? sq.op : op_ff;
    assign sq.empty   = comp_empty;
    assign sq.full    = comp_full;
    assign sq.half    = !sq.cascade && !over_half_flag_n;
    assign sq.done    = done_ff;
    assign sq.refused = refused_ff;
    assign sq.rdata   = rdata_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff + 4'h1;
        unique case (state_ff)
            AFMC_S_IDLE: begin
                nxt_cnt = 4'h0;
                if (sq.go && !go_refuse) begin
                    nxt_state = go_wr_blk ? AFMC_S_HOLD : AFMC_S_LOW;
                end
            end
            AFMC_S_HOLD: begin
                nxt_cnt = 4'h0;
                if (!comp_full) begin
                    nxt_state = AFMC_S_LOW;
                end
            end
            AFMC_S_LOW: begin
                if (rd_hold) begin
                    nxt_cnt = 4'h0;
                end else if (last_cnt) begin
                    nxt_state = AFMC_S_REC;
                    nxt_cnt   = 4'h0;
                end
            end
            AFMC_S_REC: begin
                if (rec_last) begin
                    nxt_state = AFMC_S_IDLE;
                end
            end
        endcase
    end

    // Standalone: replay pin pulses; cascade: first device held low, others high
    for (genvar i = 0; i < NDEV; i++) begin : g_lead
        assign nxt_lead[i] = sq.cascade ? (i != 0)
                           : !(nxt_low && nxt_op == AFMC_OP_RT);
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff         <= AFMC_S_IDLE;
            op_ff            <= AFMC_OP_WR;
            cnt_ff           <= 4'h0;
            seen_ff          <= 1'b0;
            done_ff          <= 1'b0;
            refused_ff       <= 1'b0;
            rdata_ff         <= '0;
            data_to_dev      <= '0;
            wr_n             <= 1'b1;
            rd_n             <= 1'b1;
            init_all_n       <= 1'b1;
            lead_or_replay_n <= '1;
        end else begin
            state_ff         <= nxt_state;
            op_ff            <= nxt_op;
            cnt_ff           <= nxt_cnt;
            // A read that starts on a word never waits, even when empty rises during it
            seen_ff          <= idle_go ? !comp_empty
                              : (state_ff == AFMC_S_LOW) && (seen_ff || !comp_empty);
            done_ff          <= (state_ff == AFMC_S_REC && rec_last) || (idle_go && go_refuse);
            refused_ff       <= idle_go && go_refuse;
            wr_n             <= !(nxt_low && nxt_op == AFMC_OP_WR);
            rd_n             <= !(nxt_low && nxt_op == AFMC_OP_RD);
            init_all_n       <= !(nxt_low && nxt_op == AFMC_OP_CLR);
            lead_or_replay_n <= nxt_lead;
            if (idle_go) begin
                data_to_dev <= sq.wdata;
            end
            if (state_ff == AFMC_S_LOW && is_rd && last_cnt && !rd_hold) begin
                rdata_ff <= data_from_dev;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_flow_wait;
        !rd_n && comp_empty && !seen_ff;
    endsequence
    sequence s_word_seen;
        !rd_n && seen_ff;
    endsequence

    a_wr_not_full: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(wr_n) |-> !$past(comp_full)) else $error("write strobe began on a full buffer");
    a_rd_not_empty: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(rd_n) && !$past(sq.wait_en) |-> !$past(comp_empty))
        else $error("read strobe began on an empty buffer");
    a_rd_flow_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_flow_wait |=> !rd_n) else $error("read strobe released before data flowed through");
    a_rd_raise_after: assert property (@(posedge aclk) disable iff (!aresetn)
        s_word_seen |-> ##[1:3] rd_n) else $error("read strobe not raised after word");
    a_wr_toggle_once: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(wr_n) |=> wr_n [*2]) else $error("write strobe not one pulse then recovery");
    a_clr_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(init_all_n) |-> wr_n && rd_n ##1 init_all_n [*2])
        else $error("clear pulse malformed or strobes not high");
    a_lead_casc: assert property (@(posedge aclk) disable iff (!aresetn)
        sq.cascade |=> !lead_or_replay_n[0]) else $error("first device not held as lead");
    a_rt_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        idle_go && sq.op == AFMC_OP_RT && sq.cascade |=> sq.refused && sq.done)
        else $error("replay accepted in cascade mode");
endmodule

//--- verilog/afmc_seq_if.sv
// Order and answer signals between the register side and the pin sequencer
`timescale 1ns/1ps
interface afmc_seq_if #(parameter int W = 9);
    logic                go;
    afmc_pkg::afmc_op_t  op;
    logic [W-1:0]        wdata;
    logic                cascade;
    logic                wait_en;
    logic                done;
    logic                refused;
    logic [W-1:0]        rdata;
    logic                empty;
    logic                full;
    logic                half;
    modport ctl (output go, op, wdata, cascade, wait_en,
                 input  done, refused, rdata, empty, full, half);
    modport seq (input  go, op, wdata, cascade, wait_en,
                 output done, refused, rdata, empty, full, half);
endinterface
